/* core/xfer_pkg.sv */
package xfer_pkg;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          RDG_W        = 16;
    localparam int          FMT_W        = 3;
    localparam int          BUF_WORDS    = 8192;
    localparam int          LVL_W        = 14;
    localparam logic [13:0] BURST_ROOM   = 14'h1000;
    localparam logic [7:0]  ADDR_CMD     = 8'h00;
    localparam logic [7:0]  ADDR_COUNT   = 8'h04;
    localparam logic [7:0]  ADDR_STATUS  = 8'h08;
    localparam logic [7:0]  ADDR_MASK    = 8'h0C;
    localparam logic [7:0]  ADDR_LASTCH  = 8'h10;
    localparam logic [7:0]  ADDR_CHAN    = 8'h14;
    localparam logic [7:0]  ADDR_MODE    = 8'h18;
    localparam int          STAT_BUSY    = 0;
    localparam int          STAT_CNTERR  = 1;
    localparam int          STAT_FULL    = 2;
    localparam int          STAT_SRQ     = 6;
    localparam int          STAT_INTR    = 9;
    localparam logic [31:0] MASK_INTR    = 32'h0000_0200;
    localparam logic [31:0] LAST_NONE    = 32'hFFFF_FFFF;
    localparam logic [31:0] CHAN_RESET   = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET   = 32'h0000_0000;
    localparam int          CMD_OP_LSB   = 0;
    localparam int          CMD_DEST_BIT = 4;
    localparam int          CMD_FMT_LSB  = 5;
    localparam int          CMD_CNT_BIT  = 8;
    localparam int          MODE_LSB     = 0;

    typedef enum logic [3:0] {
        OP_ENABLE_INTR  = 4'h0,
        OP_DISABLE_INTR = 4'h1,
        OP_CONFIGURE    = 4'h2,
        OP_MEASURE      = 4'h3,
        OP_CONFIGURE_COMMAND_MEAS    = 4'h4,
        OP_SINGLE_XFER  = 4'h5,
        OP_MULTI_XFER   = 4'h6,
        OP_SERVICE      = 4'h7,
        OP_OTHER        = 4'h8
    } op_e;

    typedef enum logic [1:0] {
        MODE_ANY      = 2'h0,
        MODE_BURST    = 2'h1,
        MODE_END      = 2'h2,
        MODE_COMPLETE = 2'h3
    } storage_mode_e;
endpackage : xfer_pkg

/* core/reading_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
module reading_buffer (
    input  wire logic                     core_clk,
    input  wire logic                     rstn,
    input  wire logic                     clear,
    input  wire logic                     overwrite,
    input  wire logic                     push,
    input  wire logic [xfer_pkg::RDG_W-1:0] pushData,
    input  wire logic                     pop,
    output logic      [xfer_pkg::RDG_W-1:0] popData,
    output logic      [xfer_pkg::LVL_W-1:0] level,
    output logic                          full
);
    import xfer_pkg::*;

    logic [RDG_W-1:0] mem [BUF_WORDS];
    logic [LVL_W-2:0] wrPtr;
    logic [LVL_W-2:0] rdPtr;
    logic             doPush;
    logic             doPop;
    logic             dropOld;

    assign full    = (level == LVL_W'(BUF_WORDS));
    // a full buffer only takes more readings when overwriting is allowed
    assign doPush  = push & (~full | overwrite);
    assign doPop   = pop & (level != '0);
    assign dropOld = doPush & full & ~doPop;

    always_ff @(posedge core_clk) begin
        if (doPush) begin
            mem[wrPtr] <= pushData;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr   <= '0;
            rdPtr   <= '0;
            level   <= '0;
            popData <= '0;
        end else if (clear) begin
            wrPtr <= '0;
            rdPtr <= '0;
            level <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doPop | dropOld) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doPop) begin
                popData <= mem[rdPtr];
            end
            if (doPush & ~doPop & ~full) begin
                level <= level + 1'b1;
            end else if (doPop & ~doPush) begin
                level <= level - 1'b1;
            end
        end
    end
endmodule : reading_buffer
`default_nettype wire

/* core/xfer_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module xfer_counter (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        load,
    input  wire logic [31:0] loadValue,
    input  wire logic        step,
    output logic             loadOk,
    output logic [30:0]      remaining
);
    import xfer_pkg::*;

    // zero and anything with the top bit set lie outside 1..2^31-1
    assign loadOk = (loadValue != 32'h0000_0000) & ~loadValue[31];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            remaining <= '0;
        end else if (load & loadOk) begin
            remaining <= loadValue[30:0];
        end else if (step & (remaining != '0)) begin
            remaining <= remaining - 1'b1;
        end
    end
endmodule : xfer_counter
`default_nettype wire

/* core/reading_transfer_interrupt_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module reading_transfer_interrupt_ctrl (
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    input  wire logic [xfer_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [xfer_pkg::DATA_W-1:0] regWdata,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic      [xfer_pkg::DATA_W-1:0] regRdata,
    input  wire logic                      rdgValid,
    input  wire logic [xfer_pkg::RDG_W-1:0]  rdgData,
    input  wire logic                      scanEnd,
    input  wire logic                      serialPoll,
    output logic                           memValid,
    output logic                           outValid,
    output logic      [xfer_pkg::RDG_W-1:0]  xferData,
    output logic      [xfer_pkg::FMT_W-1:0]  xferFormat,
    output logic                           hostBusy,
    output logic                           srq,
    output logic                           intrPending
);
    import xfer_pkg::*;

    typedef enum logic [2:0] {
        XF_IDLE    = 3'h0,
        XF_SINGLE  = 3'h1,
        XF_COUNTED = 3'h2,
        XF_WAITEND = 3'h3,
        XF_ALL     = 3'h4
    } xfer_state_e;

    ////////////////////////////////////////////////////////////////////////
    xfer_state_e       state;
    xfer_state_e       next_state;
    storage_mode_e     mode;
    logic [31:0]       countReg;
    logic [31:0]       maskReg;
    logic [31:0]       chanReg;
    logic [31:0]       lastServiced;
    logic              intrEnable;
    logic              intrFlag;
    logic              srqFlag;
    logic              scanDone;
    logic              autoMode;
    logic              countErr;
    logic              destMem;
    logic              popLag;
    logic              pop;
    logic              bufClear;
    logic              bufFull;
    logic [LVL_W-1:0]  level;
    logic [30:0]       remaining;
    logic              loadOk;
    logic              dataAvail;
    logic              intrCond;
    logic              intrFire;
    logic              cmdWr;
    op_e               op;
    logic              canPop;

    function automatic logic roomLow(input logic [LVL_W-1:0] lvl);
        return (LVL_W'(BUF_WORDS) - lvl) <= BURST_ROOM;
    endfunction : roomLow

    assign cmdWr = regWr & (regAddr == ADDR_CMD) & (state == XF_IDLE);
    assign op    = op_e'(regWdata[CMD_OP_LSB +: 4]);
    // interrupt commands keep the stored readings; transfers read them
    assign bufClear = cmdWr & (op != OP_ENABLE_INTR)
                    & (op != OP_DISABLE_INTR) & (op != OP_SINGLE_XFER)
                    & (op != OP_MULTI_XFER) & (op != OP_SERVICE);

    ////////////////////////////////////////////////////////////////////////
    reading_buffer u_buffer (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .clear     (bufClear),
        .overwrite (mode == MODE_COMPLETE),
        .push      (rdgValid),
        .pushData  (rdgData),
        .pop       (pop),
        .popData   (xferData),
        .level     (level),
        .full      (bufFull)
    );

    xfer_counter u_counter (
        .core_clk  (core_clk),
        .rstn      (rstn),
        // reloaded at every counted start so a second batch gets its count
        .load      ((regWr & (regAddr == ADDR_COUNT))
                    | (cmdWr & (op == OP_MULTI_XFER)
                       & regWdata[CMD_CNT_BIT])),
        .loadValue ((regAddr == ADDR_COUNT) ? regWdata : countReg),
        .step      (pop & (state == XF_COUNTED)),
        .loadOk    (loadOk),
        .remaining (remaining)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        unique case (mode)
            MODE_ANY:      dataAvail = level != '0;
            MODE_BURST:    dataAvail = roomLow(level) | scanDone;
            MODE_END:      dataAvail = level != '0;
            MODE_COMPLETE: dataAvail = scanDone;
        endcase
    end

    always_comb begin
        unique case (mode)
            MODE_ANY:      intrCond = level != '0;
            MODE_BURST:    intrCond = roomLow(level) | scanDone;
            MODE_END:      intrCond = scanDone;
            MODE_COMPLETE: intrCond = scanDone;
        endcase
    end

    assign canPop = dataAvail & (level != '0);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        pop        = 1'b0;
        unique case (state)
            XF_IDLE: begin
                if (autoMode & canPop) begin
                    pop = 1'b1;
                end
                if (cmdWr & (op == OP_SINGLE_XFER) & ~autoMode) begin
                    next_state = XF_SINGLE;
                end else if (cmdWr & (op == OP_MULTI_XFER)) begin
                    if (regWdata[CMD_CNT_BIT]) begin
                        if (countReg[30:0] != '0) begin
                            next_state = XF_COUNTED;
                        end
                    end else begin
                        next_state = XF_WAITEND;
                    end
                end
            end
            XF_SINGLE: begin
                if (canPop) begin
                    pop        = 1'b1;
                    next_state = XF_IDLE;
                end
            end
            XF_COUNTED: begin
                if (canPop) begin
                    pop = 1'b1;
                    if (remaining == 31'h0000_0001) begin
                        next_state = XF_IDLE;
                    end
                end
            end
            XF_WAITEND: begin
                if (scanDone) begin
                    next_state = XF_ALL;
                end
            end
            XF_ALL: begin
                if (level != '0) begin
                    pop = 1'b1;
                end
                if (level <= LVL_W'(1)) begin
                    next_state = XF_IDLE;
                end
            end
            default: begin
                next_state = XF_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= XF_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // destination and format are latched so data leave from flip-flops
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            destMem    <= 1'b0;
            xferFormat <= '0;
            autoMode   <= 1'b0;
            popLag     <= 1'b0;
        end else begin
            popLag <= pop;
            if (cmdWr & (op == OP_SINGLE_XFER | op == OP_MULTI_XFER
                         | op == OP_CONFIGURE_COMMAND_MEAS)) begin
                destMem    <= regWdata[CMD_DEST_BIT];
                xferFormat <= regWdata[CMD_FMT_LSB +: FMT_W];
            end
            if (bufClear) begin
                autoMode <= (op == OP_CONFIGURE_COMMAND_MEAS) | (op == OP_MEASURE);
            end
        end
    end

    assign memValid = popLag & destMem;
    assign outValid = popLag & ~destMem;
    assign hostBusy = state != XF_IDLE;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            countReg <= '0;
            countErr <= 1'b0;
            maskReg  <= MASK_RESET;
            chanReg  <= CHAN_RESET;
            mode     <= MODE_ANY;
            scanDone <= 1'b0;
        end else begin
            if (regWr & (regAddr == ADDR_COUNT)) begin
                countReg <= loadOk ? regWdata : 32'h0000_0000;
                countErr <= ~loadOk;
            end
            if (regWr & (regAddr == ADDR_MASK)) begin
                maskReg <= regWdata;
            end
            if (regWr & (regAddr == ADDR_CHAN)) begin
                chanReg <= regWdata;
            end
            if (regWr & (regAddr == ADDR_MODE)) begin
                mode <= storage_mode_e'(regWdata[MODE_LSB +: 2]);
            end
            // a scan end in the clearing cycle still counts
            if (scanEnd) begin
                scanDone <= 1'b1;
            end else if (bufClear) begin
                scanDone <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a new interrupt waits until both status flags have been cleared
    assign intrFire = intrEnable & intrCond & ~intrPending
                    & ~intrFlag & ~srqFlag;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            intrEnable <= 1'b0;
        end else if (regWr & (regAddr == ADDR_MODE)) begin
            intrEnable <= 1'b0;
        end else if (cmdWr) begin
            unique case (op)
                OP_ENABLE_INTR:  intrEnable <= 1'b1;
                OP_DISABLE_INTR: intrEnable <= 1'b0;
                OP_SERVICE:      intrEnable <= 1'b0;
                OP_CONFIGURE:    intrEnable <= 1'b0;
                OP_MEASURE:      intrEnable <= 1'b0;
                OP_CONFIGURE_COMMAND_MEAS:    intrEnable <= 1'b0;
                default:         intrEnable <= intrEnable;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            intrPending <= 1'b0;
        end else if (intrFire) begin
            intrPending <= 1'b1;
        end else if (cmdWr & (op == OP_CONFIGURE)) begin
            intrPending <= 1'b0;
        end else if (level == '0) begin
            intrPending <= 1'b0;
        end
    end

    // set beats clear when both land in one cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            intrFlag <= 1'b0;
            srqFlag  <= 1'b0;
        end else begin
            if (intrFire) begin
                intrFlag <= 1'b1;
            end else if (regRd & (regAddr == ADDR_STATUS)) begin
                intrFlag <= 1'b0;
            end
            if (intrFire & ((maskReg & MASK_INTR) != '0)) begin
                srqFlag <= 1'b1;
            end else if (serialPoll) begin
                srqFlag <= 1'b0;
            end
        end
    end

    assign srq = srqFlag;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lastServiced <= LAST_NONE;
        end else if (cmdWr & (op == OP_SERVICE)) begin
            lastServiced <= chanReg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= '0;
        end else if (regRd) begin
            unique case (regAddr)
                ADDR_COUNT:  regRdata <= countReg;
                ADDR_STATUS: begin
                    regRdata              <= '0;
                    regRdata[STAT_BUSY]   <= hostBusy;
                    regRdata[STAT_CNTERR] <= countErr;
                    regRdata[STAT_FULL]   <= bufFull;
                    regRdata[STAT_SRQ]    <= srqFlag;
                    regRdata[STAT_INTR]   <= intrFlag;
                end
                ADDR_MASK:   regRdata <= maskReg;
                ADDR_LASTCH: regRdata <= lastServiced;
                ADDR_CHAN:   regRdata <= chanReg;
                ADDR_MODE:   regRdata <= {30'h0000_0000, mode};
                default:     regRdata <= '0;
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_fire;
        intrFire;
    endsequence

    sequence s_status_read;
        regRd && regAddr == ADDR_STATUS && !intrFire;
    endsequence

    a_single_waits: assert property (@(posedge core_clk) disable iff (!rstn)
        state == XF_SINGLE && !canPop |=> state == XF_SINGLE)
        else $error("single transfer left without a reading");

    a_single_one: assert property (@(posedge core_clk) disable iff (!rstn)
        state == XF_SINGLE && canPop |=> state == XF_IDLE
        && (memValid || outValid))
        else $error("single transfer did not deliver one reading");

    a_clear_buffer: assert property (@(posedge core_clk) disable iff (!rstn)
        cmdWr && op == OP_CONFIGURE |=> level == '0)
        else $error("configure did not empty buffer");

    a_count_range: assert property (@(posedge core_clk) disable iff (!rstn)
        regWr && regAddr == ADDR_COUNT && regWdata == 32'h0000_0000
        |=> countErr && countReg == 32'h0000_0000)
        else $error("zero count accepted");

    a_counted_stop: assert property (@(posedge core_clk) disable iff (!rstn)
        state == XF_COUNTED && pop && remaining == 31'h0000_0001
        |=> state == XF_IDLE)
        else $error("counted transfer overran");

    a_auto_single: assert property (@(posedge core_clk) disable iff (!rstn)
        autoMode && cmdWr && op == OP_SINGLE_XFER |=> state == XF_IDLE)
        else $error("single transfer ran in auto mode");

    a_enable_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        cmdWr && (op == OP_MEASURE || op == OP_CONFIGURE_COMMAND_MEAS
        || op == OP_CONFIGURE) |=> !intrEnable ##1 !intrFire)
        else $error("measure left interrupts enabled");

    a_fire_flags: assert property (@(posedge core_clk) disable iff (!rstn)
        s_fire |=> intrFlag && intrPending)
        else $error("fire did not set flag and pending");

    a_read_clears: assert property (@(posedge core_clk) disable iff (!rstn)
        s_status_read |=> !intrFlag)
        else $error("status read kept interrupt flag");

    a_mode_disables: assert property (@(posedge core_clk) disable iff (!rstn)
        regWr && regAddr == ADDR_MODE |=> !intrEnable)
        else $error("mode change kept enable");

    a_last_none: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(rstn) |-> lastServiced == LAST_NONE)
        else $error("last channel not -1 after reset");
endmodule : reading_transfer_interrupt_ctrl
`default_nettype wire

/* tb/host_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: keeps every reading the block hands out, with its destination
module host_sink (
    input  wire logic                     core_clk,
    input  wire logic                     memValid,
    input  wire logic                     outValid,
    input  wire logic [xfer_pkg::RDG_W-1:0] xferData
);
    logic [xfer_pkg::RDG_W:0] got[$];

    // valid is high for one cycle per reading, taken mid-cycle where it has settled
    always @(negedge core_clk) begin
        if (memValid || outValid) begin
            got.push_back({memValid, xferData});
        end
    end
endmodule : host_sink
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import xfer_pkg::*;
    logic              core_clk, rstn, regWr, regRd, rdgValid, scanEnd;
    logic              serialPoll, memValid, outValid, hostBusy, srq, pend;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata;
    logic [RDG_W-1:0]  rdgData, xferData, q[$];
    logic [FMT_W-1:0]  xferFormat;
    logic [31:0]       seed;
    int                errors, checks;

    reading_transfer_interrupt_ctrl dut (.core_clk(core_clk), .rstn(rstn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .rdgValid(rdgValid),
        .rdgData(rdgData), .scanEnd(scanEnd), .serialPoll(serialPoll),
        .memValid(memValid), .outValid(outValid), .xferData(xferData),
        .xferFormat(xferFormat), .hostBusy(hostBusy), .srq(srq),
        .intrPending(pend));
    host_sink sink (.core_clk(core_clk), .memValid(memValid),
        .outValid(outValid), .xferData(xferData));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string s, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rc(input string s, input logic [7:0] a,
                      input logic [31:0] m, e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        chk(s, e, regRdata & m);
        @(posedge core_clk);
    endtask : rc
    task automatic cmd(input logic [3:0] op, input logic d, c);
        wr(ADDR_CMD, {23'h0, c, 3'h0, d, op});
    endtask : cmd
    task automatic push;
        seed = lfsr(seed);
        rdgData <= seed[15:0];
        rdgValid <= 1'b1;
        q.push_back(seed[15:0]);
        @(posedge core_clk);
        rdgValid <= 1'b0;
        @(posedge core_clk);
    endtask : push
    task automatic pls(input logic w);
        scanEnd <= w;
        serialPoll <= !w;
        @(posedge core_clk);
        scanEnd <= 1'b0;
        serialPoll <= 1'b0;
        @(posedge core_clk);
    endtask : pls
    // sampled on the falling edge so the sink's update has landed
    task automatic getx(input int n, input logic d);
        repeat (n) begin
            for (int i = 0; i < 400 && sink.got.size() == 0; i++)
                @(negedge core_clk);
            chk("xfer", {d, q.pop_front()},
                sink.got.size() ? sink.got.pop_front() : 17'h0);
        end
        @(posedge core_clk);
    endtask : getx
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // the tests need well under 2000 cycles
    initial begin
        #(50 * 20000);
        errors++;
        report_and_stop();
    end
    initial begin
        {rstn, regWr, regRd, rdgValid, scanEnd, serialPoll} = 6'h0;
        {regAddr, regWdata, rdgData} = '0;
        seed = 32'h9277;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rc("last", ADDR_LASTCH, '1, LAST_NONE);
        wr(ADDR_COUNT, 32'h0);
        rc("cnterr", ADDR_STATUS, 32'h2, 32'h2);
        wr(ADDR_COUNT, 32'h7FFFFFFF);
        rc("count", ADDR_COUNT, '1, 32'h7FFFFFFF);
        wr(ADDR_COUNT, 32'h80000000);
        rc("count", ADDR_COUNT, '1, 32'h0);
        rc("unmapped", 8'hFC, '1, 32'h0);
        $display("test 1 done");
        cmd(OP_SINGLE_XFER, 1'b0, 1'b0);
        repeat (5) @(posedge core_clk);
        chk("busy", 1, hostBusy);
        push();
        getx(1, 1'b0);
        push();
        cmd(OP_SINGLE_XFER, 1'b1, 1'b0);
        getx(1, 1'b1);
        $display("test 2 done");
        wr(ADDR_COUNT, 32'h2);
        repeat (3) push();
        cmd(OP_MULTI_XFER, 1'b0, 1'b1);
        getx(2, 1'b0);
        repeat (5) @(posedge core_clk);
        chk("extra", 0, sink.got.size());
        cmd(OP_SINGLE_XFER, 1'b0, 1'b0);
        getx(1, 1'b0);
        push();
        cmd(OP_OTHER, 1'b0, 1'b0);
        q.delete();
        cmd(OP_SINGLE_XFER, 1'b0, 1'b0);
        repeat (5) @(posedge core_clk);
        chk("busy", 1, hostBusy);
        push();
        getx(1, 1'b0);
        $display("test 3 done");
        cmd(OP_ENABLE_INTR, 1'b0, 1'b0);
        cmd(OP_MEASURE, 1'b0, 1'b0);
        q.delete();
        push();
        getx(1, 1'b0);
        repeat (4) @(posedge core_clk);
        chk("pend", 0, pend);
        cmd(OP_SINGLE_XFER, 1'b0, 1'b0);
        repeat (4) @(posedge core_clk);
        chk("busy", 0, hostBusy);
        cmd(OP_CONFIGURE, 1'b0, 1'b0);
        q.delete();
        sink.got.delete();
        $display("test 4 done");
        wr(ADDR_MODE, 32'h0);
        wr(ADDR_MASK, MASK_INTR);
        cmd(OP_ENABLE_INTR, 1'b0, 1'b0);
        push();
        repeat (3) @(posedge core_clk);
        chk("pend", 1, pend);
        chk("srq", 1, srq);
        rc("st", ADDR_STATUS, 32'h240, 32'h240);
        rc("st", ADDR_STATUS, 32'h240, 32'h040);
        pls(1'b0);
        chk("srq", 0, srq);
        wr(ADDR_CHAN, 32'h5A);
        cmd(OP_SERVICE, 1'b0, 1'b0);
        rc("last", ADDR_LASTCH, '1, 32'h5A);
        chk("pend", 1, pend);
        cmd(OP_SINGLE_XFER, 1'b0, 1'b0);
        getx(1, 1'b0);
        repeat (3) @(posedge core_clk);
        chk("pend", 0, pend);
        $display("test 5 done");
        cmd(OP_ENABLE_INTR, 1'b0, 1'b0);
        cmd(OP_DISABLE_INTR, 1'b0, 1'b0);
        push();
        repeat (4) @(posedge core_clk);
        chk("pend", 0, pend);
        cmd(OP_SINGLE_XFER, 1'b0, 1'b0);
        getx(1, 1'b0);
        cmd(OP_ENABLE_INTR, 1'b0, 1'b0);
        wr(ADDR_MODE, {30'h0, MODE_END});
        repeat (2) push();
        cmd(OP_MULTI_XFER, 1'b1, 1'b0);
        repeat (5) @(posedge core_clk);
        chk("extra", 0, sink.got.size());
        pls(1'b1);
        chk("pend", 0, pend);
        getx(2, 1'b1);
        $display("test 6 done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
